// >>> hw/supply_voltage_detect_control.sv
// control and status logic around the supply voltage detector comparators
// assumes analog comparators outside, a chip reset controller that reports the reset
// source on reset_by_detector, and an APB master on clk_sys
`timescale 1ns/10ps

module supply_voltage_detect_control (
	input  wire logic                       clk_sys,
	input  wire logic                       reset,
	input  wire logic                       reset_by_detector,
	input  wire logic [svd_pkg::REG_W-1:0]  option_byte,
	input  wire logic                       cmp_below_high,
	input  wire logic                       cmp_below_low,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [svd_pkg::ADDR_W-1:0] paddr,
	input  wire logic [svd_pkg::DATA_W-1:0] pwdata,
	output logic      [svd_pkg::DATA_W-1:0] prdata,
	output logic                            pready,
	output logic                            pslverr,
	output logic                            detector_reset_req,
	output logic                            supply_drop_irq,
	output logic                            irq
);
	reg_bus_if regs ();

	// a detector reset must not stall the detector itself, or the reset could never lift
	logic                      hard_reset;
	logic [svd_pkg::CMP_W-1:0] cmp_raw;
	logic [svd_pkg::CMP_W-1:0] cmp_filt;
	logic                      below_high;
	logic                      below_low;
	logic                      below_low_prev_q;
	logic                      below_high_prev_q;

	logic [svd_pkg::REG_W-1:0] option_q;
	logic [1:0]                mode;
	logic                      ir_mode;
	logic                      rst_mode;
	logic                      int_mode;
	logic                      det_on;

	logic                      rewrite_en_q;
	logic                      mode_bit_q;
	logic                      sel_bit_q;
	logic                      mode_bit_d;
	logic                      sel_bit_d;
	logic [svd_pkg::REG_W-1:0] level_init;

	logic [svd_pkg::SETTLE_W-1:0] settle_q;
	logic                         settle_busy;
	logic                         settle_start;
	logic                         mask_active;
	logic                         below_flag;

	logic                      drop_event;
	logic                      reset_event;
	logic                      reset_req_q;
	logic                      hold_q;
	logic                      drop_irq_q;
	logic [svd_pkg::IRQ_W-1:0] irq_status_q;
	logic [svd_pkg::IRQ_W-1:0] irq_mask_q;
	logic [svd_pkg::IRQ_W-1:0] irq_events;

	assign hard_reset = reset & ~reset_by_detector;

	assign cmp_raw[svd_pkg::CMP_HIGH] = cmp_below_high;
	assign cmp_raw[svd_pkg::CMP_LOW]  = cmp_below_low;

	cmp_sync u_sync (
		.clk_sys  (clk_sys),
		.clear    (hard_reset),
		.async_in (cmp_raw),
		.filt_out (cmp_filt)
	);

	assign below_high = cmp_filt[svd_pkg::CMP_HIGH];
	assign below_low  = cmp_filt[svd_pkg::CMP_LOW];

	svd_apb u_apb (
		.clk_sys (clk_sys),
		.reset   (reset),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.regs    (regs)
	);

	// option byte is a strap: caught while a non-detector reset is held
	always_ff @(posedge clk_sys) begin
		if (hard_reset)
			option_q <= option_byte;
	end

	assign mode     = {option_q[svd_pkg::OPT_MODE_HI], option_q[svd_pkg::OPT_MODE_LO]};
	assign ir_mode  = (mode == svd_pkg::MODE_INT_RESET);
	assign rst_mode = (mode == svd_pkg::MODE_RESET);
	assign int_mode = (mode == svd_pkg::MODE_INT);
	// any other code is treated as detector off
	assign det_on   = ir_mode | rst_mode | int_mode;

	always_comb begin
		unique case ({option_byte[svd_pkg::OPT_MODE_HI], option_byte[svd_pkg::OPT_MODE_LO]})
			svd_pkg::MODE_INT_RESET: level_init = svd_pkg::LEVEL_INIT_INT_RESET;
			svd_pkg::MODE_RESET:     level_init = svd_pkg::LEVEL_INIT_RESET;
			svd_pkg::MODE_INT:       level_init = svd_pkg::LEVEL_INIT_INT;
			default:                 level_init = svd_pkg::LEVEL_INIT_OFF;
		endcase
	end

	// rewrite enable; software keeps it low outside interrupt-and-reset mode
	always_ff @(posedge clk_sys) begin
		if (hard_reset)
			rewrite_en_q <= 1'b0;
		else if (regs.wr_ctrl && !reset)
			rewrite_en_q <= regs.wdata[svd_pkg::CTRL_REWRITE_BIT];
	end

	// mode and select bits: automatic updates beat a software write in the same cycle
	always_comb begin
		mode_bit_d = mode_bit_q;
		sel_bit_d  = sel_bit_q;
		if (ir_mode && (drop_event || reset_event)) begin
			mode_bit_d = 1'b1;
			sel_bit_d  = 1'b1;
		end else if (regs.wr_level && rewrite_en_q && !reset) begin
			mode_bit_d = regs.wdata[svd_pkg::LEVEL_MODE_BIT];
			sel_bit_d  = regs.wdata[svd_pkg::LEVEL_SEL_BIT];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (hard_reset) begin
			mode_bit_q <= level_init[svd_pkg::LEVEL_MODE_BIT];
			sel_bit_q  <= level_init[svd_pkg::LEVEL_SEL_BIT];
		end else begin
			mode_bit_q <= mode_bit_d;
			sel_bit_q  <= sel_bit_d;
		end
	end

	// settle wait after a drop interrupt or a threshold change, in interrupt-and-reset mode only
	assign settle_start = ir_mode & (drop_event | (sel_bit_d != sel_bit_q));
	assign settle_busy  = (settle_q != '0);

	always_ff @(posedge clk_sys) begin
		if (hard_reset)
			settle_q <= '0;
		else if (settle_start)
			settle_q <= svd_pkg::SETTLE_W'(svd_pkg::SETTLE_CYCLES);
		else if (settle_busy)
			settle_q <= settle_q - 1'b1;
	end

	// mask only exists in interrupt-and-reset mode
	assign mask_active = ir_mode & (rewrite_en_q | settle_busy);

	// with the detector on, the flag follows whichever comparator the select bit picks; it reads zero with the detector off
	assign below_flag = det_on & (sel_bit_q ? below_low : below_high);

	always_ff @(posedge clk_sys) begin
		// match the synchroniser's idle level so no false crossing follows reset
		if (hard_reset) begin
			below_low_prev_q  <= 1'b1;
			below_high_prev_q <= 1'b1;
		end else begin
			below_low_prev_q  <= below_low;
			below_high_prev_q <= below_high;
		end
	end

	// drop interrupt: high threshold in interrupt-and-reset mode, any low-threshold crossing in
	// interrupt mode once the start-up hold has lifted
	always_comb begin
		drop_event = 1'b0;
		if (ir_mode && !mode_bit_q && !sel_bit_q && !mask_active)
			drop_event = below_high & ~below_high_prev_q;
		else if (int_mode && !hold_q && !mode_bit_q)
			drop_event = below_low ^ below_low_prev_q;
	end

	// reset request generation in interrupt-and-reset mode
	assign reset_event = ir_mode & mode_bit_q & sel_bit_q & below_low & ~mask_active
	                   & ~reset_req_q;

	// interrupt mode keeps reset after a reset not caused by the detector until the supply clears the threshold
	always_ff @(posedge clk_sys) begin
		if (reset && !reset_by_detector)
			hold_q <= 1'b1;
		else if (!below_low)
			hold_q <= 1'b0;
	end

	always_ff @(posedge clk_sys) begin
		if (hard_reset)
			reset_req_q <= 1'b0;
		else if (rst_mode)
			reset_req_q <= below_low;
		else if (int_mode)
			reset_req_q <= hold_q & below_low;
		else if (ir_mode) begin
			if (reset_event)
				reset_req_q <= 1'b1;
			else if (!below_high)
				reset_req_q <= 1'b0;
		end else
			reset_req_q <= 1'b0;
	end

	always_ff @(posedge clk_sys) begin
		if (hard_reset)
			drop_irq_q <= 1'b0;
		else
			drop_irq_q <= drop_event;
	end

	assign detector_reset_req = reset_req_q;
	assign supply_drop_irq    = drop_irq_q;

	// sticky status: a new event beats a write-one clear in the same cycle
	assign irq_events[svd_pkg::IRQ_DROP_BIT]  = drop_event;
	assign irq_events[svd_pkg::IRQ_RESET_BIT] = reset_event |
	                                           (rst_mode & below_low & ~reset_req_q);

	always_ff @(posedge clk_sys) begin
		if (hard_reset)
			irq_status_q <= '0;
		else if (regs.wr_irq_status)
			irq_status_q <= (irq_status_q & ~regs.wdata[svd_pkg::IRQ_W-1:0]) | irq_events;
		else
			irq_status_q <= irq_status_q | irq_events;
	end

	always_ff @(posedge clk_sys) begin
		if (hard_reset)
			irq_mask_q <= '0;
		else if (regs.wr_irq_mask)
			irq_mask_q <= regs.wdata[svd_pkg::IRQ_W-1:0];
	end

	assign irq = |(irq_status_q & irq_mask_q);

	// read views; unused bits read as zero
	always_comb begin
		regs.rd_ctrl = '0;
		regs.rd_ctrl[svd_pkg::CTRL_REWRITE_BIT] = rewrite_en_q;
		regs.rd_ctrl[svd_pkg::CTRL_MASK_BIT]    = mask_active;
		regs.rd_ctrl[svd_pkg::CTRL_FLAG_BIT]    = below_flag;
		regs.rd_level = '0;
		regs.rd_level[svd_pkg::LEVEL_MODE_BIT]  = mode_bit_q;
		regs.rd_level[svd_pkg::LEVEL_SEL_BIT]   = sel_bit_q;
	end

	assign regs.rd_option     = option_q;
	assign regs.rd_irq_status = {{(svd_pkg::REG_W-svd_pkg::IRQ_W){1'b0}}, irq_status_q};
	assign regs.rd_irq_mask   = {{(svd_pkg::REG_W-svd_pkg::IRQ_W){1'b0}}, irq_mask_q};

endmodule : supply_voltage_detect_control

// >>> hw/svd_pkg.sv
// constants for the supply voltage detector control block
// assumes a 10 MHz system clock and word-aligned APB register access
package svd_pkg;

	localparam int ADDR_W = 22;
	localparam int DATA_W = 32;
	localparam int REG_W  = 8;
	localparam int CMP_W  = 2;
	localparam int IRQ_W  = 2;

	// register indices; the byte address is four times the index
	localparam logic [19:0] IDX_OPTION     = 20'h000c1;
	localparam logic [19:0] IDX_CTRL       = 20'hfffa9;
	localparam logic [19:0] IDX_LEVEL      = 20'hfffaa;
	localparam logic [19:0] IDX_IRQ_STATUS = 20'hfffab;
	localparam logic [19:0] IDX_IRQ_MASK   = 20'hfffac;

	localparam logic [ADDR_W-1:0] ADDR_OPTION     = {IDX_OPTION, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_CTRL       = {IDX_CTRL, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_LEVEL      = {IDX_LEVEL, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK   = {IDX_IRQ_MASK, 2'h0};

	// field positions
	localparam int CTRL_REWRITE_BIT = 7;
	localparam int CTRL_MASK_BIT    = 1;
	localparam int CTRL_FLAG_BIT    = 0;
	localparam int LEVEL_MODE_BIT   = 7;
	localparam int LEVEL_SEL_BIT    = 0;
	localparam int OPT_MODE_HI      = 1;
	localparam int OPT_MODE_LO      = 0;
	localparam int CMP_HIGH         = 1;
	localparam int CMP_LOW          = 0;
	localparam int IRQ_DROP_BIT     = 0;
	localparam int IRQ_RESET_BIT    = 1;

	// option byte operating modes
	localparam logic [1:0] MODE_INT_RESET = 2'h2;
	localparam logic [1:0] MODE_RESET     = 2'h3;
	localparam logic [1:0] MODE_INT       = 2'h1;

	// level register values after a reset not caused by the detector
	localparam logic [REG_W-1:0] LEVEL_INIT_INT_RESET = 8'h00;
	localparam logic [REG_W-1:0] LEVEL_INIT_RESET     = 8'h81;
	localparam logic [REG_W-1:0] LEVEL_INIT_INT       = 8'h01;
	localparam logic [REG_W-1:0] LEVEL_INIT_OFF       = 8'h00;

	// threshold settling wait
	localparam int CLK_PERIOD_NS = 100;
	localparam int SETTLE_TIME_NS = 70100;
	localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_W = 10;

endpackage : svd_pkg

// >>> hw/reg_bus_if.sv
// register strobes and read values between the APB slave and the detector core
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface reg_bus_if;
	logic                    wr_ctrl;
	logic                    wr_level;
	logic                    wr_irq_status;
	logic                    wr_irq_mask;
	logic [svd_pkg::REG_W-1:0] wdata;
	logic [svd_pkg::REG_W-1:0] rd_ctrl;
	logic [svd_pkg::REG_W-1:0] rd_level;
	logic [svd_pkg::REG_W-1:0] rd_option;
	logic [svd_pkg::REG_W-1:0] rd_irq_status;
	logic [svd_pkg::REG_W-1:0] rd_irq_mask;

	modport bus (
		output wr_ctrl, wr_level, wr_irq_status, wr_irq_mask, wdata,
		input  rd_ctrl, rd_level, rd_option, rd_irq_status, rd_irq_mask
	);
	modport core (
		input  wr_ctrl, wr_level, wr_irq_status, wr_irq_mask, wdata,
		output rd_ctrl, rd_level, rd_option, rd_irq_status, rd_irq_mask
	);
endinterface : reg_bus_if

// >>> hw/cmp_sync.sv
// three-stage synchroniser with agreement filter for the comparator outputs
// assumes the inputs are asynchronous to clk_sys
`timescale 1ns/10ps
module cmp_sync (
	input  wire logic                      clk_sys,
	input  wire logic                      clear,
	input  wire logic [svd_pkg::CMP_W-1:0] async_in,
	output logic      [svd_pkg::CMP_W-1:0] filt_out
);
	for (genvar i = 0; i < svd_pkg::CMP_W; i++) begin : g_bit
		logic s1_q;
		logic s2_q;
		logic s3_q;
		// cleared stages report below threshold: until a real sample has passed the
		// filter nothing may look healthy, or a start-up hold could lift too early
		always_ff @(posedge clk_sys) begin
			if (clear) begin
				s1_q <= 1'b1;
				s2_q <= 1'b1;
				s3_q <= 1'b1;
			end else begin
				s1_q <= async_in[i];
				s2_q <= s1_q;
				s3_q <= s2_q;
			end
		end
		// a change only counts once the two later stages agree
		always_ff @(posedge clk_sys) begin
			if (clear)
				filt_out[i] <= 1'b1;
			else if (s2_q == s3_q)
				filt_out[i] <= s3_q;
		end
	end
endmodule : cmp_sync

// >>> hw/svd_apb.sv
// APB slave front end: address decode, write strobes, registered read data
// assumes an APB master on clk_sys; answers with no wait states
`timescale 1ns/10ps
module svd_apb (
	input  wire logic                       clk_sys,
	input  wire logic                       reset,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [svd_pkg::ADDR_W-1:0] paddr,
	input  wire logic [svd_pkg::DATA_W-1:0] pwdata,
	output logic      [svd_pkg::DATA_W-1:0] prdata,
	output logic                            pready,
	output logic                            pslverr,
	reg_bus_if.bus                          regs
);
	logic                      hit;
	logic [svd_pkg::REG_W-1:0] rd_mux;
	logic                      access;

	always_comb begin
		hit    = 1'b1;
		rd_mux = '0;
		unique case (paddr)
			svd_pkg::ADDR_OPTION:     rd_mux = regs.rd_option;
			svd_pkg::ADDR_CTRL:       rd_mux = regs.rd_ctrl;
			svd_pkg::ADDR_LEVEL:      rd_mux = regs.rd_level;
			svd_pkg::ADDR_IRQ_STATUS: rd_mux = regs.rd_irq_status;
			svd_pkg::ADDR_IRQ_MASK:   rd_mux = regs.rd_irq_mask;
			default:                  hit = 1'b0;
		endcase
	end

	assign access  = psel & penable;
	assign pready  = 1'b1;
	assign pslverr = access & ~hit;

	assign regs.wdata         = pwdata[svd_pkg::REG_W-1:0];
	assign regs.wr_ctrl       = access & pwrite & (paddr == svd_pkg::ADDR_CTRL);
	assign regs.wr_level      = access & pwrite & (paddr == svd_pkg::ADDR_LEVEL);
	assign regs.wr_irq_status = access & pwrite & (paddr == svd_pkg::ADDR_IRQ_STATUS);
	assign regs.wr_irq_mask   = access & pwrite & (paddr == svd_pkg::ADDR_IRQ_MASK);

	// read data captured in the setup cycle so it comes from a flop in the access phase
	always_ff @(posedge clk_sys) begin
		if (reset)
			prdata <= '0;
		else if (psel & ~penable & ~pwrite)
			prdata <= {{(svd_pkg::DATA_W-svd_pkg::REG_W){1'b0}}, rd_mux};
	end
endmodule : svd_apb

// >>> sim/svd_cmp_model.sv
// analog comparator model: supply in millivolts against two thresholds
// assumes the bench moves supply_mv at or just after clk_sys rising edges
`timescale 1ns/10ps
module svd_cmp_model #(
	parameter int HIGH_MV = 2920,
	parameter int LOW_MV  = 2750
) (
	input  int  supply_mv,
	output wire below_high,
	output wire below_low
);
	// a small analog delay keeps edges off the clock
	assign #7 below_high = supply_mv < HIGH_MV;
	assign #7 below_low  = supply_mv < LOW_MV;
endmodule : svd_cmp_model

// >>> sim/svd_checker.sv
// port-level assertions for the detector control block
// assumes option_byte changes only while reset is high
`timescale 1ns/10ps
module svd_checker (
	input wire logic                       clk_sys,
	input wire logic                       reset,
	input wire logic [svd_pkg::REG_W-1:0]  option_byte,
	input wire logic                       cmp_below_low,
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic [svd_pkg::ADDR_W-1:0] paddr,
	input wire logic [svd_pkg::DATA_W-1:0] prdata,
	input wire logic                       pready,
	input wire logic                       pslverr,
	input wire logic                       detector_reset_req,
	input wire logic                       supply_drop_irq
);
	logic [1:0] md;
	logic       rds;
	logic       hit;
	assign md = option_byte[1:0];
	assign rds = psel && !penable && !pwrite;
	assign hit = paddr == svd_pkg::ADDR_OPTION || paddr == svd_pkg::ADDR_CTRL
		|| paddr == svd_pkg::ADDR_LEVEL || paddr == svd_pkg::ADDR_IRQ_STATUS
		|| paddr == svd_pkg::ADDR_IRQ_MASK;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	property p_ready; pready; endproperty
	a_ready: assert property (p_ready) else $error("pready low");
	property p_slverr; pslverr == (psel && penable && !hit); endproperty
	a_slverr: assert property (p_slverr) else $error("pslverr wrong");
	property p_unmapped; rds && !hit |=> prdata == '0; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_option; rds && paddr == svd_pkg::ADDR_OPTION |=> prdata == 32'(option_byte);
	endproperty
	a_option: assert property (p_option) else $error("option read wrong");
	property p_pulse; supply_drop_irq |=> !supply_drop_irq; endproperty
	a_pulse: assert property (p_pulse) else $error("drop pulse too long");
	property p_follow; (md == svd_pkg::MODE_RESET && cmp_below_low)[*8] |-> detector_reset_req;
	endproperty
	a_follow: assert property (p_follow) else $error("reset not requested");
	property p_release;
		(md == svd_pkg::MODE_RESET && !cmp_below_low)[*8] |-> !detector_reset_req;
	endproperty
	a_release: assert property (p_release) else $error("reset not released");
	property p_no_int; md == svd_pkg::MODE_RESET |-> !supply_drop_irq; endproperty
	a_no_int: assert property (p_no_int) else $error("interrupt in reset mode");
	property p_off; md == 2'h0 |-> !detector_reset_req && !supply_drop_irq; endproperty
	a_off: assert property (p_off) else $error("detector off but active");
	c_drop: cover property (supply_drop_irq);
	c_req: cover property ($rose(detector_reset_req));
	c_err: cover property (pslverr);
endmodule : svd_checker
bind supply_voltage_detect_control svd_checker u_chk (.clk_sys(clk_sys), .reset(reset),
	.option_byte(option_byte), .cmp_below_low(cmp_below_low), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .detector_reset_req(detector_reset_req),
	.supply_drop_irq(supply_drop_irq));

// >>> sim/supply_voltage_detect_control_bench.sv
// self-checking bench for the detector control block
// assumes the comparator model and the checker are compiled before it
`timescale 1ns/10ps
module supply_voltage_detect_control_bench;
	localparam logic [21:0] CT = svd_pkg::ADDR_CTRL;
	localparam logic [21:0] LV = svd_pkg::ADDR_LEVEL;
	localparam logic [21:0] ST = svd_pkg::ADDR_IRQ_STATUS;
	localparam logic [21:0] MK = svd_pkg::ADDR_IRQ_MASK;
	logic clk_sys = 0, reset = 1, reset_by_detector = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] option_byte = 8'h7a;
	logic [21:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, q;
	logic pready, pslverr, err, detector_reset_req, supply_drop_irq, irq;
	wire cmp_below_high, cmp_below_low;
	int supply_mv = 3300, mismatches = 0, n_compared = 0, cycles = 0, drops = 0;
	int seed = 17666, v;
	always #50 clk_sys = ~clk_sys;
	svd_cmp_model part (.supply_mv, .below_high(cmp_below_high), .below_low(cmp_below_low));
	supply_voltage_detect_control uut (.clk_sys, .reset, .reset_by_detector, .option_byte,
		.cmp_below_high, .cmp_below_low, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .detector_reset_req, .supply_drop_irq, .irq);
	function automatic logic [7:0] opt(input logic [1:0] m);
		return {6'b011110, m};
	endfunction : opt
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [21:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdchk(input string nm, input logic [21:0] a, input logic [31:0] e);
		apb(1'b0, a, '0);
		check(nm, q, e);
	endtask : rdchk
	task automatic do_reset(input logic [1:0] m, input logic det);
		@(posedge clk_sys);
		reset <= 1'b1;
		reset_by_detector <= det;
		if (!det) option_byte <= opt(m);
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		reset_by_detector <= 1'b0;
		repeat (10) @(posedge clk_sys);
	endtask : do_reset
	task automatic set_supply(input int s);
		supply_mv = s;
		repeat (10) @(posedge clk_sys);
	endtask : set_supply
	task automatic give_verdict();
		$display("TB: %0d compared, %0d mismatches", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict
	always @(posedge clk_sys) begin
		cycles++;
		if (supply_drop_irq === 1'b1) drops++;
		// the whole run needs about 1800 cycles
		if (cycles == 20000) begin
			mismatches++;
			give_verdict();
		end
	end
	initial begin
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		repeat (10) @(posedge clk_sys);
		rdchk("level", LV, 8'h00);
		rdchk("ctrl", CT, 8'h00);
		apb(1'b1, LV, 8'h01);
		rdchk("level", LV, 8'h00);
		apb(1'b1, CT, 8'h83);
		rdchk("ctrl", CT, 8'h82);
		apb(1'b1, LV, 8'h01);
		rdchk("level", LV, 8'h01);
		apb(1'b1, LV, 8'h00);
		apb(1'b1, CT, 8'h00);
		rdchk("ctrl", CT, 8'h02);
		repeat (720) @(posedge clk_sys);
		rdchk("ctrl", CT, 8'h00);
		set_supply(2800);
		check("drops", drops, 1);
		rdchk("level", LV, 8'h81);
		rdchk("ctrl", CT, 8'h02);
		rdchk("status", ST, 8'h01);
		check("irq", irq, 0);
		apb(1'b1, MK, 8'h01);
		#1 check("irq", irq, 1);
		apb(1'b1, ST, 8'h01);
		#1 check("irq", irq, 0);
		// settle still running, so the low threshold must not reset yet
		set_supply(2700);
		check("req", detector_reset_req, 0);
		repeat (720) @(posedge clk_sys);
		check("req", detector_reset_req, 1);
		rdchk("status", ST, 8'h02);
		do_reset(2'h2, 1'b1);
		rdchk("level", LV, 8'h81);
		rdchk("ctrl", CT, 8'h01);
		set_supply(3300);
		check("req", detector_reset_req, 0);
		do_reset(2'h3, 1'b0);
		rdchk("level", LV, 8'h81);
		for (int i = 0; i < 7; i++) begin
			v = (i == 0) ? 2750 : 2500 + {$random(seed)} % 500;
			set_supply(v);
			apb(1'b1, CT, {$random(seed)} & 32'h7f);
			rdchk("ctrl", CT, 32'(v < 2750));
			check("req", detector_reset_req, 32'(v < 2750));
		end
		// interrupt mode entered with the supply low: reset holds until it recovers
		set_supply(2700);
		do_reset(2'h1, 1'b0);
		check("req", detector_reset_req, 1);
		rdchk("level", LV, 8'h01);
		v = drops;
		set_supply(3300);
		check("req", detector_reset_req, 0);
		check("drops", drops - v, 0);
		set_supply(2700);
		set_supply(3300);
		check("drops", drops - v, 2);
		check("req", detector_reset_req, 0);
		do_reset(2'h0, 1'b0);
		rdchk("level", LV, 8'h00);
		set_supply(2700);
		rdchk("ctrl", CT, 8'h00);
		apb(1'b1, svd_pkg::ADDR_OPTION, 8'h00);
		rdchk("option", svd_pkg::ADDR_OPTION, opt(2'h0));
		apb(1'b0, 22'h000100, '0);
		check("slverr", err, 1);
		check("rdata", q, 0);
		give_verdict();
	end
endmodule : supply_voltage_detect_control_bench
